// ===== uart_rx_pkg.sv
package uart_rx_pkg;

  // register port
  localparam int ADDR_WIDTH = 4;
  localparam int DATA_WIDTH = 8;

  // register offsets
  localparam logic [3:0] OFF_RCV_STATUS = 4'h0;
  localparam logic [3:0] OFF_RCV_DATA = 4'h1;
  localparam logic [3:0] OFF_DIV_LOW = 4'h2;
  localparam logic [3:0] OFF_DIV_HIGH = 4'h3;
  localparam logic [3:0] OFF_TX_STATUS = 4'h4;
  localparam logic [3:0] OFF_BAUD_CTRL = 4'h5;
  localparam logic [3:0] OFF_INT_CTRL = 4'h6;
  localparam logic [3:0] OFF_IRQ_ENABLE = 4'h7;
  localparam logic [3:0] OFF_IRQ_FLAGS = 4'h8;

  // receive_status_control fields
  localparam int BIT_SERIAL_PORT_ENABLE = 7;
  localparam int BIT_RX9 = 6;
  localparam int BIT_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int BIT_ADDRESS_DETECT_ENABLE = 3;
  localparam int BIT_FRAMING_ERROR_FLAG = 2;
  localparam int BIT_OVERRUN_FLAG = 1;
  localparam int BIT_NINTH = 0;
  // transmit_status_control fields
  localparam int BIT_SYNC = 4;
  localparam int BIT_HIGH_SPEED_BAUD_SELECT = 2;
  localparam int BIT_TRMT = 1;
  // baud_control fields
  localparam int BIT_IDLE = 6;
  localparam int BIT_WIDE_DIVISOR_SELECT = 3;
  // interrupt_control fields
  localparam int BIT_GIE = 7;
  localparam int BIT_PERIPHERAL_INTERRUPT_ENABLE = 6;
  // peripheral irq enable and flag fields
  localparam int BIT_RECEIVE_INTERRUPT_ENABLE = 5;
  localparam int BIT_RECEIVE_FLAG = 5;

  // reset values
  localparam logic [7:0] RST_RCV_STATUS = 8'h00;
  localparam logic [7:0] RST_DIV = 8'h00;
  localparam logic [7:0] RST_TX_STATUS = 8'h02;
  localparam logic [7:0] RST_BAUD_CTRL = 8'h00;
  localparam logic [7:0] RST_INT_CTRL = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;

  // timing counts
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_MID = 4'h8;
  localparam logic [3:0] SAMPLE_LAST = 4'h9;
  localparam logic [1:0] LOW_SPEED_LAST = 2'h3;
  localparam logic [3:0] LAST_BIT_NINE = 4'h8;
  localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
  localparam int FIFO_DEPTH = 2;
  localparam int CHAR_WIDTH = 9;
  localparam int DIV_WIDTH = 16;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_STOP
  } rx_state_type;

endpackage

// ===== baud_tick_gen.sv
`timescale 1ns/1ps
// one-cycle pulse at sixteen times the bit rate
module baud_tick_gen #(
  parameter int DIV_WIDTH = uart_rx_pkg::DIV_WIDTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // control
  input wire logic run,
  input wire logic [DIV_WIDTH-1:0] divisor,
  input wire logic high_speed,
  // oversample enable
  output logic tick
);

  logic [DIV_WIDTH-1:0] cnt_reg;
  logic [1:0] pre_reg;

  // low speed stretches each divisor period four times
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !run) begin
      cnt_reg <= '0;
      pre_reg <= 2'h0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (cnt_reg == '0) begin
        cnt_reg <= divisor;
        pre_reg <= pre_reg + 2'h1;
        if (high_speed || pre_reg == uart_rx_pkg::LOW_SPEED_LAST) begin
          tick <= 1'b1;
          pre_reg <= 2'h0;
        end
      end else begin
        cnt_reg <= cnt_reg - DIV_WIDTH'(1);
      end
    end
  end

endmodule // baud_tick_gen

// ===== uart_rx_overrun_addr_detect.sv
`timescale 1ns/1ps
// How it works
// - two-entry FIFO, read in arrival order
// - third full character sets overrun flag
// - overrun keeps entries readable, blocks new ones
// - only receive or port disable clears overrun
// - nine-bit select shifts nine data bits
// - ninth bit of head character shown
// - address mode keeps only ninth-bit-set characters
// - receive flag on store; interrupt if enabled
// - address mode characters show ninth bit one
// - interrupt needs receive, peripheral, global enables
// - line oversampled sixteen times per bit
// - zero stop bit marks framing error
// - receive flag while enabled and data buffered
module uart_rx_overrun_addr_detect #(
  parameter int FIFO_DEPTH = uart_rx_pkg::FIFO_DEPTH,
  parameter int CHAR_WIDTH = uart_rx_pkg::CHAR_WIDTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [uart_rx_pkg::ADDR_WIDTH-1:0] addr,
  input wire logic [uart_rx_pkg::DATA_WIDTH-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [uart_rx_pkg::DATA_WIDTH-1:0] rd_data,
  // serial line
  input wire logic rx_pin,
  // processor interrupt request
  output logic irq
);

  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(FIFO_DEPTH);

  function automatic logic majority3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p);
    if (p == PTR_W'(FIFO_DEPTH - 1)) begin
      return '0;
    end
    return p + PTR_W'(1);
  endfunction

  // control bits
  logic serial_port_enable_reg, nine_bit_receive_select_reg, continuous_receive_enable_reg;
  logic address_detect_enable_reg, synchronous_select_reg, high_speed_baud_select_reg;
  logic wide_divisor_select_reg, global_interrupt_enable_reg, peripheral_interrupt_enable_reg;
  logic receive_interrupt_enable_reg;
  logic [7:0] baud_divisor_low_reg, baud_divisor_high_reg;

  // line synchroniser
  logic rx_meta_reg, rx_s2_reg, rx_s3_reg, rx_line_reg;

  // recovery state
  uart_rx_pkg::rx_state_type state_reg;
  logic [3:0] phase_reg, bit_idx_reg;
  logic samp_a_reg, samp_b_reg;
  logic [CHAR_WIDTH-1:0] receive_shift_register_reg;
  logic char_done_reg, char_framing_error_flag_reg;
  logic [CHAR_WIDTH-1:0] char_word_reg;

  // buffer
  logic [CHAR_WIDTH-1:0] fifo_data_reg [FIFO_DEPTH];
  logic fifo_framing_error_flag_reg [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [CNT_W-1:0] fill_reg;
  logic overrun_flag_reg;

  logic rx_on, tick, bit_now, accept, pop, room, push, head_valid;
  logic framing_error_flag, receive_ninth_bit, receive_flag;
  logic [3:0] last_idx;
  logic [uart_rx_pkg::DIV_WIDTH-1:0] divisor;
  logic [uart_rx_pkg::DATA_WIDTH-1:0] read_value;

  assign rx_on = serial_port_enable_reg && continuous_receive_enable_reg
                 && !synchronous_select_reg;
  assign divisor = wide_divisor_select_reg ?
                   {baud_divisor_high_reg, baud_divisor_low_reg} :
                   {8'h00, baud_divisor_low_reg};

  baud_tick_gen #(.DIV_WIDTH(uart_rx_pkg::DIV_WIDTH)) i_baud_tick_gen (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(serial_port_enable_reg),
    .divisor(divisor),
    .high_speed(high_speed_baud_select_reg),
    .tick(tick)
  );

  // register writes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      serial_port_enable_reg <= uart_rx_pkg::RST_RCV_STATUS[uart_rx_pkg::BIT_SERIAL_PORT_ENABLE];
      nine_bit_receive_select_reg <= uart_rx_pkg::RST_RCV_STATUS[uart_rx_pkg::BIT_RX9];
      continuous_receive_enable_reg <= uart_rx_pkg::RST_RCV_STATUS[uart_rx_pkg::BIT_CONTINUOUS_RECEIVE_ENABLE];
      address_detect_enable_reg <= uart_rx_pkg::RST_RCV_STATUS[uart_rx_pkg::BIT_ADDRESS_DETECT_ENABLE];
      synchronous_select_reg <= uart_rx_pkg::RST_TX_STATUS[uart_rx_pkg::BIT_SYNC];
      high_speed_baud_select_reg <= uart_rx_pkg::RST_TX_STATUS[uart_rx_pkg::BIT_HIGH_SPEED_BAUD_SELECT];
      wide_divisor_select_reg <= uart_rx_pkg::RST_BAUD_CTRL[uart_rx_pkg::BIT_WIDE_DIVISOR_SELECT];
      global_interrupt_enable_reg <= uart_rx_pkg::RST_INT_CTRL[uart_rx_pkg::BIT_GIE];
      peripheral_interrupt_enable_reg <= uart_rx_pkg::RST_INT_CTRL[uart_rx_pkg::BIT_PERIPHERAL_INTERRUPT_ENABLE];
      receive_interrupt_enable_reg <= uart_rx_pkg::RST_IRQ_ENABLE[uart_rx_pkg::BIT_RECEIVE_INTERRUPT_ENABLE];
      baud_divisor_low_reg <= uart_rx_pkg::RST_DIV;
      baud_divisor_high_reg <= uart_rx_pkg::RST_DIV;
    end else if (wr_en) begin
      case (addr)
        uart_rx_pkg::OFF_RCV_STATUS: begin
          serial_port_enable_reg <= wr_data[uart_rx_pkg::BIT_SERIAL_PORT_ENABLE];
          nine_bit_receive_select_reg <= wr_data[uart_rx_pkg::BIT_RX9];
          continuous_receive_enable_reg <= wr_data[uart_rx_pkg::BIT_CONTINUOUS_RECEIVE_ENABLE];
          address_detect_enable_reg <= wr_data[uart_rx_pkg::BIT_ADDRESS_DETECT_ENABLE];
        end
        uart_rx_pkg::OFF_DIV_LOW: begin
          baud_divisor_low_reg <= wr_data;
        end
        uart_rx_pkg::OFF_DIV_HIGH: begin
          baud_divisor_high_reg <= wr_data;
        end
        uart_rx_pkg::OFF_TX_STATUS: begin
          synchronous_select_reg <= wr_data[uart_rx_pkg::BIT_SYNC];
          high_speed_baud_select_reg <= wr_data[uart_rx_pkg::BIT_HIGH_SPEED_BAUD_SELECT];
        end
        uart_rx_pkg::OFF_BAUD_CTRL: begin
          wide_divisor_select_reg <= wr_data[uart_rx_pkg::BIT_WIDE_DIVISOR_SELECT];
        end
        uart_rx_pkg::OFF_INT_CTRL: begin
          global_interrupt_enable_reg <= wr_data[uart_rx_pkg::BIT_GIE];
          peripheral_interrupt_enable_reg <= wr_data[uart_rx_pkg::BIT_PERIPHERAL_INTERRUPT_ENABLE];
        end
        uart_rx_pkg::OFF_IRQ_ENABLE: begin
          receive_interrupt_enable_reg <= wr_data[uart_rx_pkg::BIT_RECEIVE_INTERRUPT_ENABLE];
        end
        default: begin
        end
      endcase
    end
  end

  // pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_meta_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_s3_reg <= 1'b1;
      rx_line_reg <= 1'b1;
    end else begin
      rx_meta_reg <= rx_pin;
      rx_s2_reg <= rx_meta_reg;
      rx_s3_reg <= rx_s2_reg;
      if (rx_s2_reg == rx_s3_reg) begin
        rx_line_reg <= rx_s3_reg;
      end
    end
  end

  // three samples around mid-bit, voted
  assign bit_now = majority3(samp_a_reg, samp_b_reg, rx_line_reg);
  assign last_idx = nine_bit_receive_select_reg ? uart_rx_pkg::LAST_BIT_NINE :
                    uart_rx_pkg::LAST_BIT_EIGHT;

  // recovery runs on the oversample enable; phase wraps every sixteen ticks
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !rx_on) begin
      state_reg <= uart_rx_pkg::ST_IDLE;
      phase_reg <= 4'h0;
      bit_idx_reg <= 4'h0;
      samp_a_reg <= 1'b1;
      samp_b_reg <= 1'b1;
      receive_shift_register_reg <= '0;
    end else if (tick) begin
      phase_reg <= phase_reg + 4'h1;
      if (phase_reg == uart_rx_pkg::SAMPLE_FIRST) begin
        samp_a_reg <= rx_line_reg;
      end
      if (phase_reg == uart_rx_pkg::SAMPLE_MID) begin
        samp_b_reg <= rx_line_reg;
      end
      unique case (state_reg)
        uart_rx_pkg::ST_IDLE: begin
          phase_reg <= {3'h0, !rx_line_reg};
          if (!rx_line_reg) begin
            state_reg <= uart_rx_pkg::ST_START;
          end
        end
        uart_rx_pkg::ST_START: begin
          if (phase_reg == uart_rx_pkg::SAMPLE_LAST) begin
            // a glitch that is high by mid-bit is dropped silently
            if (bit_now) begin
              state_reg <= uart_rx_pkg::ST_IDLE;
            end else begin
              state_reg <= uart_rx_pkg::ST_DATA;
              bit_idx_reg <= 4'h0;
              receive_shift_register_reg <= '0;
            end
          end
        end
        uart_rx_pkg::ST_DATA: begin
          if (phase_reg == uart_rx_pkg::SAMPLE_LAST) begin
            receive_shift_register_reg[bit_idx_reg] <= bit_now;
            if (bit_idx_reg == last_idx) begin
              state_reg <= uart_rx_pkg::ST_STOP;
            end else begin
              bit_idx_reg <= bit_idx_reg + 4'h1;
            end
          end
        end
        uart_rx_pkg::ST_STOP: begin
          if (phase_reg == uart_rx_pkg::SAMPLE_LAST) begin
            state_reg <= uart_rx_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // character complete at the stop bit sample
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      char_done_reg <= 1'b0;
      char_word_reg <= '0;
      char_framing_error_flag_reg <= 1'b0;
    end else begin
      char_done_reg <= rx_on && tick && state_reg == uart_rx_pkg::ST_STOP
                       && phase_reg == uart_rx_pkg::SAMPLE_LAST;
      if (rx_on && tick && state_reg == uart_rx_pkg::ST_STOP
          && phase_reg == uart_rx_pkg::SAMPLE_LAST) begin
        char_word_reg <= receive_shift_register_reg;
        char_framing_error_flag_reg <= !bit_now;
      end
    end
  end

  // without nine-bit select the ninth bit is zero, so address mode keeps nothing
  assign accept = !address_detect_enable_reg
                  || (nine_bit_receive_select_reg && char_word_reg[CHAR_WIDTH-1]);
  assign head_valid = fill_reg != '0;
  assign pop = rd_en && addr == uart_rx_pkg::OFF_RCV_DATA && head_valid;
  // a read in the same cycle frees the slot in time
  assign room = fill_reg != FULL_COUNT || pop;
  assign push = char_done_reg && rx_on && accept && !overrun_flag_reg && room;

  // storage is left as is on overrun; empty entries are never shown
  always_ff @(posedge ref_clk) begin
    if (push) begin
      fifo_data_reg[wr_ptr_reg] <= char_word_reg;
      fifo_framing_error_flag_reg[wr_ptr_reg] <= char_framing_error_flag_reg;
    end
  end

  // port disable resets the unit and empties the buffer
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !serial_port_enable_reg) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fill_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_step(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_step(rd_ptr_reg);
      end
      if (push && !pop) begin
        fill_reg <= fill_reg + CNT_W'(1);
      end else if (pop && !push) begin
        fill_reg <= fill_reg - CNT_W'(1);
      end
    end
  end

  // cleared at the very write that drops receive or port enable; buffer kept only when receive enable drops
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !serial_port_enable_reg || !continuous_receive_enable_reg
        || (wr_en && addr == uart_rx_pkg::OFF_RCV_STATUS
            && !(wr_data[uart_rx_pkg::BIT_SERIAL_PORT_ENABLE] && wr_data[uart_rx_pkg::BIT_CONTINUOUS_RECEIVE_ENABLE]))) begin
      overrun_flag_reg <= 1'b0;
    end else if (char_done_reg && rx_on && accept && !room) begin
      overrun_flag_reg <= 1'b1;
    end
  end

  assign framing_error_flag = head_valid && fifo_framing_error_flag_reg[rd_ptr_reg];
  assign receive_ninth_bit = head_valid && fifo_data_reg[rd_ptr_reg][CHAR_WIDTH-1];
  assign receive_flag = rx_on && head_valid;

  // read decode; unmapped offsets read zero
  always_comb begin
    read_value = '0;
    case (addr)
      uart_rx_pkg::OFF_RCV_STATUS: begin
        read_value[uart_rx_pkg::BIT_SERIAL_PORT_ENABLE] = serial_port_enable_reg;
        read_value[uart_rx_pkg::BIT_RX9] = nine_bit_receive_select_reg;
        read_value[uart_rx_pkg::BIT_CONTINUOUS_RECEIVE_ENABLE] = continuous_receive_enable_reg;
        read_value[uart_rx_pkg::BIT_ADDRESS_DETECT_ENABLE] = address_detect_enable_reg;
        read_value[uart_rx_pkg::BIT_FRAMING_ERROR_FLAG] = framing_error_flag;
        read_value[uart_rx_pkg::BIT_OVERRUN_FLAG] = overrun_flag_reg;
        read_value[uart_rx_pkg::BIT_NINTH] = receive_ninth_bit;
      end
      uart_rx_pkg::OFF_RCV_DATA: begin
        if (head_valid) begin
          read_value = fifo_data_reg[rd_ptr_reg][7:0];
        end
      end
      uart_rx_pkg::OFF_DIV_LOW: begin
        read_value = baud_divisor_low_reg;
      end
      uart_rx_pkg::OFF_DIV_HIGH: begin
        read_value = baud_divisor_high_reg;
      end
      uart_rx_pkg::OFF_TX_STATUS: begin
        read_value[uart_rx_pkg::BIT_SYNC] = synchronous_select_reg;
        read_value[uart_rx_pkg::BIT_HIGH_SPEED_BAUD_SELECT] = high_speed_baud_select_reg;
        // no transmitter here, so its shift register always reads empty
        read_value[uart_rx_pkg::BIT_TRMT] = uart_rx_pkg::RST_TX_STATUS[uart_rx_pkg::BIT_TRMT];
      end
      uart_rx_pkg::OFF_BAUD_CTRL: begin
        read_value[uart_rx_pkg::BIT_IDLE] = state_reg == uart_rx_pkg::ST_IDLE;
        read_value[uart_rx_pkg::BIT_WIDE_DIVISOR_SELECT] = wide_divisor_select_reg;
      end
      uart_rx_pkg::OFF_INT_CTRL: begin
        read_value[uart_rx_pkg::BIT_GIE] = global_interrupt_enable_reg;
        read_value[uart_rx_pkg::BIT_PERIPHERAL_INTERRUPT_ENABLE] = peripheral_interrupt_enable_reg;
      end
      uart_rx_pkg::OFF_IRQ_ENABLE: begin
        read_value[uart_rx_pkg::BIT_RECEIVE_INTERRUPT_ENABLE] = receive_interrupt_enable_reg;
      end
      uart_rx_pkg::OFF_IRQ_FLAGS: begin
        read_value[uart_rx_pkg::BIT_RECEIVE_FLAG] = receive_flag;
      end
      default: begin
      end
    endcase
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_en ? read_value : '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= receive_flag && receive_interrupt_enable_reg
             && peripheral_interrupt_enable_reg && global_interrupt_enable_reg;
    end
  end

endmodule // uart_rx_overrun_addr_detect

// ===== uart_rx_monitor.sv
`timescale 1ns/1ps
module uart_rx_monitor #(
  parameter int FIFO_DEPTH = uart_rx_pkg::FIFO_DEPTH,
  parameter int CHAR_WIDTH = uart_rx_pkg::CHAR_WIDTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [uart_rx_pkg::ADDR_WIDTH-1:0] addr,
  input wire logic [uart_rx_pkg::DATA_WIDTH-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [uart_rx_pkg::DATA_WIDTH-1:0] rd_data,
  // serial line and interrupt
  input wire logic rx_pin,
  input wire logic irq
);
  logic [3:0] ctrl_reg;
  logic [2:0] ints_reg;
  logic [7:0] div_low_reg;
  logic rcv_off;
  // shadows of what software wrote, so outputs can be tied to their causes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) ctrl_reg <= 4'h0;
    else if (wr_en && addr == uart_rx_pkg::OFF_RCV_STATUS)
      ctrl_reg <= {wr_data[7], wr_data[6], wr_data[4], wr_data[3]};
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) ints_reg <= 3'h0;
    else if (wr_en && addr == uart_rx_pkg::OFF_INT_CTRL) ints_reg[2:1] <= wr_data[7:6];
    else if (wr_en && addr == uart_rx_pkg::OFF_IRQ_ENABLE) ints_reg[0] <= wr_data[5];
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) div_low_reg <= 8'h00;
    else if (wr_en && addr == uart_rx_pkg::OFF_DIV_LOW) div_low_reg <= wr_data;
  end
  assign rcv_off = !(ctrl_reg[3] && ctrl_reg[1]);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_rd_idle; !rd_en |=> rd_data == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
  property p_irq_gated; irq |-> $past(ints_reg) == 3'h7; endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("interrupt without all enables");
  property p_overrun_flag_clear;
    rd_en && addr == uart_rx_pkg::OFF_RCV_STATUS && !ctrl_reg[1] |=> !rd_data[uart_rx_pkg::BIT_OVERRUN_FLAG];
  endproperty
  a_overrun_flag_clear: assert property (p_overrun_flag_clear) else $error("overrun seen with receive off");
  property p_receive_flag_gated;
    rd_en && addr == uart_rx_pkg::OFF_IRQ_FLAGS && rcv_off && $past(rcv_off)
      |=> !rd_data[uart_rx_pkg::BIT_RECEIVE_FLAG];
  endproperty
  a_receive_flag_gated: assert property (p_receive_flag_gated) else $error("receive flag with receiver off");
  property p_trmt; rd_en && addr == uart_rx_pkg::OFF_TX_STATUS |=> rd_data[1]; endproperty
  a_trmt: assert property (p_trmt) else $error("transmit empty bit not one");
  property p_unmapped; rd_en && addr > uart_rx_pkg::OFF_IRQ_FLAGS |=> rd_data == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_div_readback; rd_en && addr == uart_rx_pkg::OFF_DIV_LOW |=> rd_data == div_low_reg;
  endproperty
  a_div_readback: assert property (p_div_readback) else $error("divisor low readback wrong");
  property p_ctrl_readback;
    rd_en && addr == uart_rx_pkg::OFF_RCV_STATUS
      |=> {rd_data[7], rd_data[6], rd_data[4], rd_data[3]} == $past(ctrl_reg);
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) else $error("status control bits wrong");
  c_overrun: cover property (rd_en && addr == uart_rx_pkg::OFF_RCV_STATUS ##1 rd_data[1]);
  c_irq: cover property ($rose(irq));
  c_ninth: cover property (rd_en && addr == uart_rx_pkg::OFF_RCV_STATUS ##1 rd_data[0]);
  c_line_start: cover property ($fell(rx_pin));
endmodule // uart_rx_monitor

bind uart_rx_overrun_addr_detect uart_rx_monitor #(.FIFO_DEPTH(FIFO_DEPTH),
  .CHAR_WIDTH(CHAR_WIDTH)) i_uart_rx_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .rx_pin(rx_pin), .irq(irq));

// ===== serial_line_model.sv
`timescale 1ns/1ps
module serial_line_model #(
  parameter int BIT_CYCLES = 16
) (
  // clock
  input wire logic ref_clk,
  // serial line, idles high between frames
  output logic rx_line
);
  initial rx_line = 1'b1;
  // start, eight or nine data bits lsb first, one stop bit; a bad stop is held low past the
  // sample point only, so the receiver does not mistake it for the next start
  task automatic send(input logic [8:0] ch, input logic stop_ok, input int gap, input int nbits);
    logic [10:0] frame;
    frame = (nbits == 8) ? {1'b1, stop_ok, ch[7:0], 1'b0} : {stop_ok, ch, 1'b0};
    for (int i = 0; i < nbits + 2; i++) begin
      @(posedge ref_clk);
      rx_line <= frame[i];
      if (i == nbits + 1 && !stop_ok) begin
        repeat (10) @(posedge ref_clk);
        rx_line <= 1'b1;
        repeat (5) @(posedge ref_clk);
      end else begin
        repeat (BIT_CYCLES - 1) @(posedge ref_clk);
      end
    end
    repeat (gap) @(posedge ref_clk);
  endtask
endmodule // serial_line_model

// ===== test_uart_rx_overrun_addr_detect.sv
`timescale 1ns/1ps
module test_uart_rx_overrun_addr_detect;
  localparam logic [3:0] ST = uart_rx_pkg::OFF_RCV_STATUS;
  localparam logic [3:0] DAT = uart_rx_pkg::OFF_RCV_DATA;
  localparam logic [3:0] DL = uart_rx_pkg::OFF_DIV_LOW;
  localparam logic [3:0] FL = uart_rx_pkg::OFF_IRQ_FLAGS;
  localparam logic [3:0] IE = uart_rx_pkg::OFF_IRQ_ENABLE;
  logic ref_clk, sys_rst, wr_en, rd_en, irq, rx_line;
  logic [3:0] addr;
  logic [7:0] wr_data, rd_data, d;
  int failures = 0;
  int n_tests = 0;

  uart_rx_overrun_addr_detect i_uart_rx_overrun_addr_detect (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .rx_pin(rx_line), .irq(irq));
  serial_line_model i_serial_line_model (.ref_clk(ref_clk), .rx_line(rx_line));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] mask,
                        input logic [7:0] exp);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    d = rd_data;
    check(name, d & mask, exp);
  endtask
  task automatic tx(input logic [8:0] ch, input logic ok);
    i_serial_line_model.send(ch, ok, 0, 9);
  endtask
  task automatic end_sim;
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    end_sim;
  end

  initial begin
    sys_rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'h0;
    wr_data = 8'h00;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk("status rst", ST, 8'hFF, uart_rx_pkg::RST_RCV_STATUS);
    rd_chk("div high rst", uart_rx_pkg::OFF_DIV_HIGH, 8'hFF, uart_rx_pkg::RST_DIV);
    rd_chk("tx status rst", uart_rx_pkg::OFF_TX_STATUS, 8'hFF, uart_rx_pkg::RST_TX_STATUS);
    rd_chk("int ctrl rst", uart_rx_pkg::OFF_INT_CTRL, 8'hFF, uart_rx_pkg::RST_INT_CTRL);
    rd_chk("irq enable rst", IE, 8'hFF, uart_rx_pkg::RST_IRQ_ENABLE);
    rd_chk("unmapped", 4'hF, 8'hFF, 8'h00);
    // baud first: divisor 0 with high speed gives one oversample tick per clock
    wr(DL, 8'h5A);
    rd_chk("div low", DL, 8'hFF, 8'h5A);
    wr(DL, 8'h00);
    wr(uart_rx_pkg::OFF_DIV_HIGH, 8'h00);
    wr(uart_rx_pkg::OFF_TX_STATUS, 8'h04);
    wr(uart_rx_pkg::OFF_BAUD_CTRL, 8'h00);
    wr(ST, 8'h80);
    wr(uart_rx_pkg::OFF_INT_CTRL, 8'hC0);
    wr(IE, 8'h20);
    wr(ST, 8'hC0);
    rd_chk("flag before enable", FL, 8'h20, 8'h00);
    wr(ST, 8'hD0);
    // two characters buffered, ninth bit follows the head
    tx(9'h1A5, 1'b1);
    tx(9'h03C, 1'b1);
    repeat (4) @(posedge ref_clk);
    rd_chk("flag set", FL, 8'h20, 8'h20);
    check("irq on", {7'h00, irq}, 8'h01);
    wr(IE, 8'h00);
    repeat (2) @(posedge ref_clk);
    check("irq masked", {7'h00, irq}, 8'h00);
    rd_chk("flag masked", FL, 8'h20, 8'h20);
    wr(IE, 8'h20);
    rd_chk("ninth one", ST, 8'h07, 8'h01);
    rd_chk("data first", DAT, 8'hFF, 8'hA5);
    rd_chk("ninth zero", ST, 8'h07, 8'h00);
    rd_chk("data second", DAT, 8'hFF, 8'h3C);
    rd_chk("flag empty", FL, 8'h20, 8'h00);
    repeat (2) @(posedge ref_clk);
    check("irq off", {7'h00, irq}, 8'h00);
    // overrun with a framing error at the head, then one more while overrun
    tx(9'h111, 1'b0);
    tx(9'h122, 1'b1);
    tx(9'h033, 1'b1);
    tx(9'h144, 1'b1);
    repeat (4) @(posedge ref_clk);
    rd_chk("overrun", ST, 8'h07, 8'h07);
    wr(ST, 8'hC0);
    rd_chk("overrun cleared", ST, 8'h07, 8'h05);
    wr(ST, 8'hD0);
    rd_chk("kept head", DAT, 8'hFF, 8'h11);
    rd_chk("second status", ST, 8'h07, 8'h01);
    rd_chk("kept second", DAT, 8'hFF, 8'h22);
    rd_chk("none accepted", DAT, 8'hFF, 8'h00);
    // port disable also recovers from overrun and empties the buffer
    tx(9'h0E7, 1'b1);
    tx(9'h0E8, 1'b1);
    tx(9'h0E9, 1'b1);
    repeat (4) @(posedge ref_clk);
    wr(ST, 8'h00);
    wr(ST, 8'hD0);
    rd_chk("port reset", ST, 8'h06, 8'h00);
    rd_chk("port emptied", DAT, 8'hFF, 8'h00);
    // address detection
    wr(ST, 8'hD8);
    tx(9'h055, 1'b1);
    tx(9'h1C3, 1'b1);
    repeat (4) @(posedge ref_clk);
    rd_chk("address ninth", ST, 8'h01, 8'h01);
    rd_chk("address kept", DAT, 8'hFF, 8'hC3);
    rd_chk("data dropped", DAT, 8'hFF, 8'h00);
    wr(ST, 8'hD0);
    tx(9'h077, 1'b1);
    repeat (4) @(posedge ref_clk);
    rd_chk("data after match", DAT, 8'hFF, 8'h77);
    wr(ST, 8'hD8);
    tx(9'h066, 1'b1);
    repeat (4) @(posedge ref_clk);
    rd_chk("rearmed drop", FL, 8'h20, 8'h00);
    // eight-bit frames: the stop bit must not be taken as a ninth data bit
    wr(ST, 8'h90);
    i_serial_line_model.send(9'h15A, 1'b1, 0, 8);
    repeat (4) @(posedge ref_clk);
    rd_chk("eight status", ST, 8'h07, 8'h00);
    rd_chk("eight data", DAT, 8'hFF, 8'h5A);
    end_sim;
  end
endmodule // test_uart_rx_overrun_addr_detect
